// File: logic/rgtbd_top.sv
// Red/green compressed texture block decoder, top level.
// Assumes block fetch and sampling logic on the same clock; reset is a pin.
//
// What this block does
// R01: Image is 4x4 texel blocks of 64 or 128 bits.
// R02: Image size is ceil(w/4)*ceil(h/4)*block bytes, 8 or 16.
// R03: Block offset is blocksize*(ceil(w/4)*floor(y/4)+floor(x/4)).
// R04: Texel inside block chosen by x mod 4 and y mod 4.
// R05: Texels outside a small image may decode to anything.
// R06: Half block bytes: endpoint 0, endpoint 1, six selector bytes.
// R07: Selector bytes joined little-endian into a 48-bit vector.
// R08: Unsigned endpoints normalise like an unsigned byte intensity pixel.
// R09: Code of texel is vector bits 3*(4y+x)+2 down to 3*(4y+x).
// R10: First endpoint greater: codes 0,1 endpoints, 2..7 sevenths blend.
// R11: Otherwise: 0,1 endpoints, 2..5 fifths, 6 minimum, 7 maximum.
// R12: One-channel output is (R, 0, 0, 1).
// R13: Signed endpoints are byte/127, -128 gives -1; range -1 to 1.
// R14: Ordering of -127 against -128 may go either way; remap allowed.
// R15: Encoders should not emit first -127 with second -128.
// R16: Unsigned two-channel: first half red, second half green, (R,G,0,1).
// R17: Signed two-channel: both halves signed, red then green, (R,G,0,1).
// R18: Four formats: unsigned and signed, one and two channel.
// R19: Request under valid/ready, texel returned with valid at fixed latency.
`timescale 1ns/100ps
`include "rgtbd_params.svh"

module rgtbd_top (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // Block locate request
    input wire logic i_addr_valid,
    input rgtbd_pkg::rgtbd_addr_req_s i_addr_req,
    // Block locate answer
    output logic o_addr_valid,
    output rgtbd_pkg::rgtbd_addr_rsp_s o_addr_rsp,
    // Texel decode request
    input wire logic i_dec_valid,
    input rgtbd_pkg::rgtbd_dec_req_s i_dec_req,
    output logic o_dec_ready,
    // Decoded texel
    output logic o_tex_valid,
    output rgtbd_pkg::rgtbd_texel_s o_texel,
    output logic o_tex_signed
);
    import rgtbd_pkg::*;

    //////////////////////////////////////////////////////////////////////////
    // Reset release through two flops; assertion stays asynchronous
    logic rst_meta_q, rst_meta_d;
    logic rst_sync_q, rst_sync_d;
    logic rst_n;

    always_comb begin
        rst_meta_d = 1'b1;
        rst_sync_d = rst_meta_q;
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= rst_meta_d;
            rst_sync_q <= rst_sync_d;
        end
    end

    assign rst_n = rst_sync_q;

    //////////////////////////////////////////////////////////////////////////
    // Unpack one 64-bit half into endpoints, order and this texel's code
    function automatic rgtbd_chan_s unpack_half(
        input logic [`RGTBD_HALF_BITS-1:0] half,
        input logic is_signed,
        input logic [3:0] texel_idx
    );
        rgtbd_chan_s c;
        logic [7:0] b0;
        logic [7:0] b1;
        logic [47:0] sel;
        b0 = half[7:0]; // R06
        b1 = half[15:8]; // R06
        sel = half[`RGTBD_HALF_BITS-1:`RGTBD_SEL_LSB]; // R07
        if (is_signed) begin
            // Remapping -128 to -127 keeps the scale exact: both mean -1.0
            c.e0 = (b0 == `RGTBD_SNEG_MIN) ? `RGTBD_SNEG_REMAP : {b0[7], b0}; // R13 R14
            c.e1 = (b1 == `RGTBD_SNEG_MIN) ? `RGTBD_SNEG_REMAP : {b1[7], b1}; // R13 R14
        end else begin
            c.e0 = {1'b0, b0}; // R08
            c.e1 = {1'b0, b1}; // R08
        end
        // Compare after the remap, so -127 against -128 reads as equal
        c.gt = c.e0 > c.e1; // R10 R11 R14
        c.code = sel[6'(3 * texel_idx) +: 3]; // R09
        return c;
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // Block locator
    rgtbd_addr u_addr (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(rst_n),
        .i_valid(i_addr_valid),
        .i_req(i_addr_req),
        .o_valid(o_addr_valid),
        .o_rsp(o_addr_rsp)
    );

    //////////////////////////////////////////////////////////////////////////
    // Request acceptance; pipeline never stalls, so ready only waits reset
    logic ready_q, ready_d;
    logic take;

    assign take = i_dec_valid && ready_q; // R19

    always_comb begin
        ready_d = 1'b1;
    end

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= ready_d;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Stage 1: unpacked channels and format
    logic s1_valid_q, s1_valid_d;
    rgtbd_fmt_e s1_fmt_q, s1_fmt_d;
    rgtbd_chan_s s1_chan_q [2];
    rgtbd_chan_s s1_chan_d [2];
    logic [3:0] texel_idx;

    // Local position in the block is the low two bits of each coordinate
    // Texels past the edge of a small image decode as usual; caller ignores them
    assign texel_idx = {i_dec_req.y[1:0], i_dec_req.x[1:0]}; // R04 R05

    always_comb begin
        s1_valid_d = take;
        s1_fmt_d = s1_fmt_q;
        s1_chan_d = s1_chan_q;
        if (take) begin
            s1_fmt_d = i_dec_req.fmt; // R18
            s1_chan_d[0] = unpack_half(i_dec_req.block[`RGTBD_HALF_BITS-1:0],
                fmt_is_signed(i_dec_req.fmt), texel_idx); // R16 R17
            s1_chan_d[1] = unpack_half(
                i_dec_req.block[`RGTBD_BLOCK_BITS-1:`RGTBD_HALF_BITS],
                fmt_is_signed(i_dec_req.fmt), texel_idx); // R01 R16 R17
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s1_valid_q <= 1'b0;
            s1_fmt_q <= unsigned_one_channel_format;
            s1_chan_q[0] <= '0;
            s1_chan_q[1] <= '0;
        end else begin
            s1_valid_q <= s1_valid_d;
            s1_fmt_q <= s1_fmt_d;
            s1_chan_q <= s1_chan_d;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Stage 2: interpolators, one per half; green half unused in one-channel
    rgtbd_comp_t chan_val [2];
    logic s1_signed;

    assign s1_signed = fmt_is_signed(s1_fmt_q);

    generate
        for (genvar gi = 0; gi < 2; gi++) begin : g_chan
            rgtbd_chan u_chan (
                .i_clk_sys(i_clk_sys),
                .i_rst_n(rst_n),
                .i_chan(s1_chan_q[gi]),
                .i_signed(s1_signed),
                .o_value(chan_val[gi])
            );
        end
    endgenerate

    logic s2_valid_q, s2_valid_d;
    rgtbd_fmt_e s2_fmt_q, s2_fmt_d;

    always_comb begin
        s2_valid_d = s1_valid_q;
        s2_fmt_d = s1_valid_q ? s1_fmt_q : s2_fmt_q;
    end

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s2_valid_q <= 1'b0;
            s2_fmt_q <= unsigned_one_channel_format;
        end else begin
            s2_valid_q <= s2_valid_d;
            s2_fmt_q <= s2_fmt_d;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Output stage: assemble RGBA; held between texels
    logic tex_valid_q, tex_valid_d;
    logic tex_signed_q, tex_signed_d;
    rgtbd_texel_s texel_q, texel_d;

    always_comb begin
        tex_valid_d = s2_valid_q; // R19
        tex_signed_d = tex_signed_q;
        texel_d = texel_q;
        if (s2_valid_q) begin
            tex_signed_d = fmt_is_signed(s2_fmt_q);
            texel_d.r = chan_val[0]; // R12 R16 R17
            texel_d.g = fmt_is_two(s2_fmt_q) ? chan_val[1] : 16'sh0000; // R12 R16 R17
            texel_d.b = 16'sh0000; // R12
            texel_d.a = fmt_is_signed(s2_fmt_q) ? `RGTBD_SCALE_S : `RGTBD_SCALE_U; // R12
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tex_valid_q <= 1'b0;
            tex_signed_q <= 1'b0;
            texel_q <= '0;
        end else begin
            tex_valid_q <= tex_valid_d;
            tex_signed_q <= tex_signed_d;
            texel_q <= texel_d;
        end
    end

    assign o_dec_ready = ready_q;
    assign o_tex_valid = tex_valid_q;
    assign o_texel = texel_q;
    assign o_tex_signed = tex_signed_q;

endmodule

// File: logic/rgtbd_params.svh
// Constants for the red/green texture block decoder: sizes, scales, timing.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef RGTBD_PARAMS_SVH
`define RGTBD_PARAMS_SVH

// Texel coordinate and image dimension width
`define RGTBD_COORD_W 14
// Block geometry
`define RGTBD_HALF_BITS 64
`define RGTBD_BLOCK_BITS 128
`define RGTBD_SEL_LSB 16
// Block size as a byte shift: 8 bytes one channel, 16 bytes two channel
`define RGTBD_SHIFT_ONE 3
`define RGTBD_SHIFT_TWO 4
// Output scale: 1.0 equals 255*35 unsigned, 127*35 signed
`define RGTBD_SCALE_U 16'sh22DD
`define RGTBD_SCALE_S 16'sh115D
`define RGTBD_MUL_EP 18'sh23
`define RGTBD_MUL_SEVENTHS 18'sh5
`define RGTBD_MUL_FIFTHS 18'sh7
// Signed endpoint byte that is remapped, and its replacement
`define RGTBD_SNEG_MIN 8'h80
`define RGTBD_SNEG_REMAP 9'h181
// Cycles from the taking edge to the valid texel
`define RGTBD_LATENCY 2

`endif

// File: logic/rgtbd_pkg.sv
// Types shared by the red/green texture block decoder modules.
// Assumes the constants header sits beside it on the include path.
`include "rgtbd_params.svh"

package rgtbd_pkg;

    typedef enum logic [1:0] {
        unsigned_one_channel_format,
        signed_one_channel_format,
        unsigned_two_channel_format,
        signed_two_channel_format
    } rgtbd_fmt_e;

    typedef logic [`RGTBD_COORD_W-1:0] rgtbd_coord_t;
    typedef logic signed [15:0] rgtbd_comp_t;

    // Decode request: block bytes in address order, byte n at bits 8n+7:8n
    typedef struct packed {
        rgtbd_fmt_e fmt;
        logic [`RGTBD_BLOCK_BITS-1:0] block;
        rgtbd_coord_t x;
        rgtbd_coord_t y;
    } rgtbd_dec_req_s;

    typedef struct packed {
        rgtbd_fmt_e fmt;
        rgtbd_coord_t width;
        rgtbd_coord_t height;
        rgtbd_coord_t x;
        rgtbd_coord_t y;
    } rgtbd_addr_req_s;

    typedef struct packed {
        logic [31:0] offset;
        logic [31:0] size;
    } rgtbd_addr_rsp_s;

    typedef struct packed {
        rgtbd_comp_t r;
        rgtbd_comp_t g;
        rgtbd_comp_t b;
        rgtbd_comp_t a;
    } rgtbd_texel_s;

    // One unpacked channel: endpoints, their order and this texel's code
    typedef struct packed {
        logic signed [8:0] e0;
        logic signed [8:0] e1;
        logic gt;
        logic [2:0] code;
    } rgtbd_chan_s;

    function automatic logic fmt_is_signed(input rgtbd_fmt_e fmt);
        return (fmt == signed_one_channel_format) || (fmt == signed_two_channel_format);
    endfunction

    function automatic logic fmt_is_two(input rgtbd_fmt_e fmt);
        return (fmt == unsigned_two_channel_format) || (fmt == signed_two_channel_format);
    endfunction

endpackage

// File: logic/rgtbd_addr.sv
// Block locator: byte offset of a texel's block and the whole image size.
// Assumes a synchronised active-low reset and requests on the same clock.
`timescale 1ns/100ps
`include "rgtbd_params.svh"

module rgtbd_addr (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Request
    input wire logic i_valid,
    input rgtbd_pkg::rgtbd_addr_req_s i_req,
    // Answer
    output logic o_valid,
    output rgtbd_pkg::rgtbd_addr_rsp_s o_rsp
);
    import rgtbd_pkg::*;

    logic valid_q, valid_d;
    rgtbd_addr_rsp_s rsp_q, rsp_d;
    logic [`RGTBD_COORD_W:0] w_ext;
    logic [`RGTBD_COORD_W:0] h_ext;
    logic [`RGTBD_COORD_W-2:0] blocks_w;
    logic [`RGTBD_COORD_W-2:0] blocks_h;
    logic [31:0] block_idx;
    logic [31:0] block_cnt;

    //////////////////////////////////////////////////////////////////////////
    // Blocks per row and column round up; partial blocks still take space
    always_comb begin
        w_ext = {1'b0, i_req.width} + {{(`RGTBD_COORD_W-1){1'b0}}, 2'h3};
        h_ext = {1'b0, i_req.height} + {{(`RGTBD_COORD_W-1){1'b0}}, 2'h3};
        blocks_w = w_ext[`RGTBD_COORD_W:2];
        blocks_h = h_ext[`RGTBD_COORD_W:2];
        block_idx = 32'(blocks_w * i_req.y[`RGTBD_COORD_W-1:2])
            + 32'(i_req.x[`RGTBD_COORD_W-1:2]); // R03
        block_cnt = 32'(blocks_w * blocks_h);
        valid_d = i_valid;
        rsp_d = rsp_q;
        if (i_valid) begin
            if (fmt_is_two(i_req.fmt)) begin
                rsp_d.offset = block_idx << `RGTBD_SHIFT_TWO; // R03
                rsp_d.size = block_cnt << `RGTBD_SHIFT_TWO; // R02
            end else begin
                rsp_d.offset = block_idx << `RGTBD_SHIFT_ONE; // R03
                rsp_d.size = block_cnt << `RGTBD_SHIFT_ONE; // R02
            end
        end
    end

    // Answer register
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            valid_q <= 1'b0;
            rsp_q <= '0;
        end else begin
            valid_q <= valid_d;
            rsp_q <= rsp_d;
        end
    end

    assign o_valid = valid_q;
    assign o_rsp = rsp_q;

endmodule

// File: logic/rgtbd_chan.sv
// One channel interpolator: turns endpoints and a 3-bit code into a value.
// Assumes unpacked endpoints from the top; result is registered.
`timescale 1ns/100ps
`include "rgtbd_params.svh"

module rgtbd_chan (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Unpacked channel
    input rgtbd_pkg::rgtbd_chan_s i_chan,
    input wire logic i_signed,
    // Interpolated value, 1.0 at the format's scale
    output rgtbd_pkg::rgtbd_comp_t o_value
);
    import rgtbd_pkg::*;

    rgtbd_comp_t value_q, value_d;
    logic [3:0] w0;
    logic [3:0] w1;
    logic signed [17:0] acc;
    logic signed [17:0] scaled;

    //////////////////////////////////////////////////////////////////////////
    // All values kept as exact multiples of 1/35 of an endpoint step, so
    // sevenths and fifths need no divider and no rounding
    always_comb begin
        w0 = 4'h0;
        w1 = 4'h0;
        if (i_chan.gt) begin
            w0 = 4'h8 - {1'b0, i_chan.code}; // R10
            w1 = {1'b0, i_chan.code} - 4'h1; // R10
        end else begin
            w0 = 4'h6 - {1'b0, i_chan.code}; // R11
            w1 = {1'b0, i_chan.code} - 4'h1; // R11
        end
        acc = 18'($signed({1'b0, w0}) * i_chan.e0) + 18'($signed({1'b0, w1}) * i_chan.e1);
        scaled = i_chan.gt ? 18'(acc * `RGTBD_MUL_SEVENTHS) : 18'(acc * `RGTBD_MUL_FIFTHS);
        unique case (i_chan.code)
            3'h0: value_d = 16'(18'(i_chan.e0 * `RGTBD_MUL_EP)); // R10 R11
            3'h1: value_d = 16'(18'(i_chan.e1 * `RGTBD_MUL_EP)); // R10 R11
            3'h6: begin
                if (i_chan.gt) begin
                    value_d = scaled[15:0]; // R10
                end else if (i_signed) begin
                    value_d = -`RGTBD_SCALE_S; // R13
                end else begin
                    value_d = 16'sh0000; // R11
                end
            end
            3'h7: begin
                if (i_chan.gt) begin
                    value_d = scaled[15:0]; // R10
                end else begin
                    value_d = i_signed ? `RGTBD_SCALE_S : `RGTBD_SCALE_U; // R11 R13
                end
            end
            default: value_d = scaled[15:0]; // R10 R11
        endcase
    end

    // Result register
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            value_q <= '0;
        end else begin
            value_q <= value_d;
        end
    end

    assign o_value = value_q;

endmodule

// File: dv/rgtbd_top_sva.sv
// Port checker for the texture block decoder.
// Assumes it is bound into rgtbd_top and sees one clock domain.
`timescale 1ns/100ps
`include "rgtbd_params.svh"

module rgtbd_top_sva (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // Locate
    input wire logic i_addr_valid,
    input rgtbd_pkg::rgtbd_addr_req_s i_addr_req,
    input wire logic o_addr_valid,
    input rgtbd_pkg::rgtbd_addr_rsp_s o_addr_rsp,
    // Decode
    input wire logic i_dec_valid,
    input rgtbd_pkg::rgtbd_dec_req_s i_dec_req,
    input wire logic o_dec_ready,
    input wire logic o_tex_valid,
    input rgtbd_pkg::rgtbd_texel_s o_texel,
    input wire logic o_tex_signed
);
    import rgtbd_pkg::*;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    ////////////////////////////////////////
    // Reference figures worked out on the request side
    logic take, one_ch, sg, u_c0, u_c7;
    logic [2:0] code;
    logic [31:0] wb, hb, bsh, exp_size, exp_off;
    assign take = i_dec_valid && o_dec_ready;
    assign code = i_dec_req.block[`RGTBD_SEL_LSB + 3 * {i_dec_req.y[1:0], i_dec_req.x[1:0]} +: 3];
    assign one_ch = !i_dec_req.fmt[1];
    assign sg = i_dec_req.fmt[0];
    assign u_c0 = (i_dec_req.fmt == unsigned_one_channel_format) && (code == 3'h0);
    // Code 7 means maximum only when the endpoints are not descending
    assign u_c7 = (i_dec_req.fmt == unsigned_one_channel_format) && (code == 3'h7)
        && (i_dec_req.block[7:0] <= i_dec_req.block[15:8]);
    assign wb = (32'(i_addr_req.width) + 32'h3) >> 2;
    assign hb = (32'(i_addr_req.height) + 32'h3) >> 2;
    assign bsh = i_addr_req.fmt[1] ? `RGTBD_SHIFT_TWO : `RGTBD_SHIFT_ONE;
    assign exp_size = (wb * hb) << bsh;
    assign exp_off = (wb * 32'(i_addr_req.y >> 2) + 32'(i_addr_req.x >> 2)) << bsh;
    ////////////////////////////////////////
    sequence s_take;
        take;
    endsequence
    sequence s_answer;
        ##3 o_tex_valid;
    endsequence
    AST_TEX_LATENCY: assert property (s_take |-> s_answer)
        else $error("texel not returned three cycles after take");
    AST_TEX_CAUSE: assert property (o_tex_valid |-> $past(take, 3))
        else $error("texel without a request");
    AST_READY_HOLDS: assert property ($rose(o_dec_ready) |-> o_dec_ready [*8])
        else $error("ready dropped");
    AST_ADDR_SIZE: assert property (i_addr_valid && o_dec_ready |=>
        o_addr_valid && o_addr_rsp.size == $past(exp_size)) else $error("image size wrong");
    AST_ADDR_OFFSET: assert property (o_addr_valid |-> o_addr_rsp.offset == $past(exp_off))
        else $error("block offset wrong");
    AST_ONE_CHAN: assert property (o_tex_valid && $past(one_ch, 3) |-> o_texel.g == 16'h0)
        else $error("one channel green not zero");
    AST_ALPHA_ONE: assert property (o_tex_valid |-> o_texel.b == 16'h0
        && o_texel.a == (o_tex_signed ? `RGTBD_SCALE_S : `RGTBD_SCALE_U))
        else $error("blue or alpha wrong");
    AST_SIGNED_FLAG: assert property (o_tex_valid |-> o_tex_signed == $past(sg, 3))
        else $error("signed flag wrong");
    AST_CODE0_END: assert property (o_tex_valid && $past(u_c0, 3) |->
        o_texel.r == 16'($past(i_dec_req.block[7:0], 3)) * 16'h23) else $error("code 0 wrong");
    AST_CODE7_MAX: assert property (o_tex_valid && $past(u_c7, 3) |->
        o_texel.r == `RGTBD_SCALE_U) else $error("code 7 not maximum");
endmodule

bind rgtbd_top rgtbd_top_sva i_sva (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
    .i_addr_valid(i_addr_valid), .i_addr_req(i_addr_req), .o_addr_valid(o_addr_valid),
    .o_addr_rsp(o_addr_rsp), .i_dec_valid(i_dec_valid), .i_dec_req(i_dec_req),
    .o_dec_ready(o_dec_ready), .o_tex_valid(o_tex_valid), .o_texel(o_texel),
    .o_tex_signed(o_tex_signed));

// File: dv/rgtbd_fetch_model.sv
// Block fetch side model: hands decode requests to the decoder.
// Assumes the decoder's clock; requests change 1 ns after an edge.
`timescale 1ns/100ps

module rgtbd_fetch_model (
    // Clock
    input wire logic i_clk_sys,
    // Decode request toward the decoder
    input wire logic i_dec_ready,
    output logic o_dec_valid,
    output rgtbd_pkg::rgtbd_dec_req_s o_dec_req
);
    import rgtbd_pkg::*;
    initial begin
        o_dec_valid = 1'b0;
        o_dec_req = '0;
    end
    ////////////////////////////////////////
    // Hold the request until an edge samples ready high
    task automatic send(input rgtbd_dec_req_s req);
        #1;
        o_dec_valid = 1'b1;
        o_dec_req = req;
        do begin
            @(posedge i_clk_sys);
        end while (i_dec_ready !== 1'b1);
    endtask
    // Released data shows the inverse, so a stale copy cannot pass
    task automatic idle();
        #1;
        o_dec_valid = 1'b0;
        o_dec_req.block = ~o_dec_req.block;
    endtask
endmodule

// File: dv/rgtbd_tb_top.sv
// Self-checking bench for the texture block decoder.
// Assumes the checker binds itself and the fetch model drives decode.
`timescale 1ns/100ps
`include "rgtbd_params.svh"

module rgtbd_tb_top;
    import rgtbd_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_addr_valid = 1'b0;
    rgtbd_addr_req_s i_addr_req = '0;
    logic o_addr_valid, i_dec_valid, o_dec_ready, o_tex_valid, o_tex_signed;
    rgtbd_addr_rsp_s o_addr_rsp;
    rgtbd_dec_req_s i_dec_req;
    rgtbd_texel_s o_texel;
    int fail_count = 0;
    int tests_run = 0;
    logic [64:0] exp_q[$];

    always #5 i_clk_sys = ~i_clk_sys;

    rgtbd_top i_dut (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
        .i_addr_valid(i_addr_valid), .i_addr_req(i_addr_req), .o_addr_valid(o_addr_valid),
        .o_addr_rsp(o_addr_rsp), .i_dec_valid(i_dec_valid), .i_dec_req(i_dec_req),
        .o_dec_ready(o_dec_ready), .o_tex_valid(o_tex_valid), .o_texel(o_texel),
        .o_tex_signed(o_tex_signed));
    rgtbd_fetch_model i_fetch (.i_clk_sys(i_clk_sys), .i_dec_ready(o_dec_ready),
        .o_dec_valid(i_dec_valid), .o_dec_req(i_dec_req));
    ////////////////////////////////////////
    task automatic check(input string what, input logic [64:0] seen, input logic [64:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One channel value, 1.0 at 35 times the full byte
    function automatic logic [15:0] chan(input logic [63:0] h, input logic sg,
        input logic [3:0] idx);
        int a, b, k, lo, hi;
        a = h[7:0];
        b = h[15:8];
        lo = 0;
        hi = 255;
        if (sg) begin
            a = $signed(h[7:0]);
            b = $signed(h[15:8]);
            lo = -127;
            hi = 127;
            if (a == -128) a = -127;
            if (b == -128) b = -127;
        end
        k = h[`RGTBD_SEL_LSB + 3 * idx +: 3];
        if (k == 0) return 16'(a * 35);
        if (k == 1) return 16'(b * 35);
        if (a > b) return 16'(((8 - k) * a + (k - 1) * b) * 5);
        if (k < 6) return 16'(((6 - k) * a + (k - 1) * b) * 7);
        return 16'((k == 6 ? lo : hi) * 35);
    endfunction

    // Selector vector giving texel i the code i plus rot
    function automatic logic [47:0] sel(input int rot);
        logic [47:0] v;
        for (int i = 0; i < 16; i++) v[3 * i +: 3] = 3'(i + rot);
        return v;
    endfunction

    // Every texel of a block back to back; coordinates beyond 4 test the wrap
    task automatic run_block(input string what, input rgtbd_fmt_e f, input logic [127:0] blk);
        logic [15:0] g;
        for (int i = 0; i < 16; i++) begin
            g = f[1] ? chan(blk[127:64], f[0], i[3:0]) : 16'h0;
            exp_q.push_back({f[0], chan(blk[63:0], f[0], i[3:0]), g, 16'h0,
                f[0] ? `RGTBD_SCALE_S : `RGTBD_SCALE_U});
            i_fetch.send('{fmt: f, block: blk, x: 14'(4 * i + i % 4), y: 14'(8 + i / 4)});
        end
        i_fetch.idle();
        for (int n = 0; n < 8 && exp_q.size() > 0; n++) @(posedge i_clk_sys);
        check({what, " drained"}, 65'(exp_q.size()), 65'h0);
        $display("%s done", what);
    endtask

    // Texels are judged mid-cycle, where the pulse has settled
    always @(negedge i_clk_sys) begin
        if (o_tex_valid === 1'b1) begin
            if (exp_q.size() == 0) check("spare texel", 65'h1, 65'h0);
            else check("texel", {o_tex_signed, o_texel}, exp_q.pop_front());
        end
    end
    ////////////////////////////////////////
    // Locate requests back to back, each answer checked one edge later
    task automatic t_locate();
        int w[4] = '{5, 4, 1, 1000};
        int h[4] = '{3, 4, 1, 17};
        int x[4] = '{4, 3, 0, 999};
        int y[4] = '{2, 3, 0, 16};
        int bs;
        logic [63:0] e;
        for (int i = 0; i <= 4; i++) begin
            @(posedge i_clk_sys);
            #1;
            if (i > 0) check("locate", {o_addr_valid, o_addr_rsp}, {1'b1, e});
            i_addr_valid = (i < 4);
            if (i < 4) begin
                bs = (i % 2) ? 16 : 8;
                e = {32'(bs * (((w[i] + 3) / 4) * (y[i] / 4) + x[i] / 4)),
                    32'(((w[i] + 3) / 4) * ((h[i] + 3) / 4) * bs)};
                i_addr_req = '{fmt: rgtbd_fmt_e'(2'(2 * (i % 2) + i / 2)), width: 14'(w[i]),
                    height: 14'(h[i]), x: 14'(x[i]), y: 14'(y[i])};
            end
        end
        $display("locate done");
    endtask

    task automatic t_unsigned_one();
        run_block("unsigned gt", unsigned_one_channel_format, {64'hA55A, sel(0), 8'h0A, 8'hC8});
        run_block("unsigned le", unsigned_one_channel_format, {64'h0, sel(3), 8'hC8, 8'h0A});
    endtask

    task automatic t_signed_one();
        run_block("signed le", signed_one_channel_format, {64'h0, sel(1), 8'h64, 8'h80});
        run_block("signed gt", signed_one_channel_format, {64'h1, sel(5), 8'h81, 8'h7F});
    endtask

    task automatic t_two_channel();
        run_block("unsigned two", unsigned_two_channel_format,
            {sel(6), 8'hFF, 8'h00, sel(2), 8'h10, 8'hF0});
        run_block("signed two", signed_two_channel_format,
            {sel(7), 8'h20, 8'hE0, sel(4), 8'h80, 8'h7F});
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (3) @(posedge i_clk_sys);
        #1;
        i_reset_n = 1'b1;
        for (int n = 0; n < 8 && o_dec_ready !== 1'b1; n++) begin
            @(posedge i_clk_sys);
            #1;
        end
        check("ready", 65'(o_dec_ready), 65'h1);
        t_locate();
        t_unsigned_one();
        t_signed_one();
        t_two_channel();
        tally_and_finish();
    end

    // Watchdog well beyond the fewer than two hundred cycles the tests need
    initial begin
        #20000;
        fail_count++;
        $display("[ERR] watchdog expected done seen hang");
        tally_and_finish();
    end
endmodule
